// ### rtl/rlsa_consts.svh
// Constants of the remote link supervision and alarm acknowledge block
// Assumes a 20 MHz clock and a 16-bit set value path
// How it works
// R1 - Supervise only active digital remote link
// R2 - Each message restarts timeout; silence means expiry
// R3 - Expiry drops remote control to manual
// R4 - Expiry turns output off or keeps it
// R5 - New timeout applies after current period ends
// R6 - Separate from network connection timeout
// R7 - Analog active refuses digital; digital ignores select
// R8 - Select pin low requests analog control
// R9 - Lock ends digital; analog only pauses
// R10 - Analog needs select; standby pin switches output in analog only
// R11 - Analog takes all four set values together
// R12 - Scale to chosen range; reference follows
// R13 - Clip analog set values to limits
// R14 - Protection thresholds never from analog port
// R15 - Shown set values are analog ones
// R16 - Host ignores status outputs during start
// R17 - Any alarm disables output as in manual
// R18 - Configurable alarm routing to two outputs
// R19 - Latched alarms cleared by standby pulse low
// R20 - Power fail, overtemp need ack if off
// R21 - Safety overvoltage never clears; shows both
// R22 - Common millisecond tick drives both timers
`ifndef RLSA_CONSTS_SVH
`define RLSA_CONSTS_SVH
`define RLSA_CLK_HZ 20000000
`define RLSA_MS_PER_S 1000
`define RLSA_MS_CYC (`RLSA_CLK_HZ / `RLSA_MS_PER_S)
`define RLSA_ACK_LOW_MS 50
`define RLSA_SV_W 16
`define RLSA_TO_W 16
`define RLSA_TO_RST_MS 1000
`define RLSA_ALM_MASTER_SLAVE 0
`define RLSA_ALM_OVERVOLT 1
`define RLSA_ALM_OVERCURR 2
`define RLSA_ALM_OVERPOWER 3
`define RLSA_ALM_PWR_FAIL 4
`define RLSA_ALM_OVERTEMP 5
`define RLSA_ALM_N 6
`endif

// ### rtl/rlsa_pkg.sv
// Types of the remote link supervision block
// Assumes rlsa_consts.svh is on the include path
`include "rlsa_consts.svh"
package rlsa_pkg;
	typedef enum logic [1:0] {
		RLSA_LOC_MANUAL = 2'b00,
		RLSA_LOC_DIGITAL = 2'b01,
		RLSA_LOC_ANALOG = 2'b10
	} rlsa_loc_e;
	typedef logic [`RLSA_SV_W-1:0] rlsa_sv_t;
	typedef logic [`RLSA_ALM_N-1:0] rlsa_alm_t;
	typedef struct packed {
		rlsa_loc_e loc;
		logic [16:0] ms_div;
		logic ms_tick;
		logic [`RLSA_TO_W-1:0] to_cnt;
		logic [`RLSA_TO_W-1:0] to_len;
		logic expired;
		logic out_on;
		logic sb_prev;
		logic [5:0] low_ms;
		rlsa_alm_t latched;
		logic safety_ov;
		logic dig_err;
		logic ack;
		rlsa_sv_t v_set;
		rlsa_sv_t c_set;
		rlsa_sv_t p_set;
		rlsa_sv_t r_set;
		rlsa_sv_t v_mon;
		rlsa_sv_t c_mon;
		logic range10;
		logic alarm1;
		logic alarm2;
	} rlsa_state_s;
endpackage

// ### rtl/rlsa_top.sv
// Remote link supervision, analog arbitration and alarm acknowledge
// Assumes synchronous pins and set values full scale 16-bit codes
`timescale 1ns/1ns
`default_nettype none
`include "rlsa_consts.svh"
module rlsa_top (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Digital remote link
	input wire logic dig_req,
	input wire logic dig_release,
	input wire logic dig_msg,
	input wire logic to_wr,
	input wire logic [`RLSA_TO_W-1:0] to_ms,
	input wire logic keep_on_after_remote,
	input wire logic local_lock,
	// Output switching from manual side
	input wire logic manual_out_on,
	// Analog port inputs
	input wire logic remote_select_n,
	input wire logic output_standby_pin,
	input wire logic range_10v,
	input wire logic range_10v_cfg,
	input wire rlsa_pkg::rlsa_sv_t voltage_setpoint_input,
	input wire rlsa_pkg::rlsa_sv_t current_setpoint_input,
	input wire rlsa_pkg::rlsa_sv_t power_setpoint_input,
	input wire rlsa_pkg::rlsa_sv_t resistance_setpoint_input,
	// Manual set values, limits and actual values
	input wire rlsa_pkg::rlsa_sv_t man_v,
	input wire rlsa_pkg::rlsa_sv_t man_c,
	input wire rlsa_pkg::rlsa_sv_t man_p,
	input wire rlsa_pkg::rlsa_sv_t man_r,
	input wire rlsa_pkg::rlsa_sv_t lim_v,
	input wire rlsa_pkg::rlsa_sv_t lim_c,
	input wire rlsa_pkg::rlsa_sv_t lim_p,
	input wire rlsa_pkg::rlsa_sv_t lim_r,
	input wire rlsa_pkg::rlsa_sv_t act_v,
	input wire rlsa_pkg::rlsa_sv_t act_c,
	// Alarms
	input wire rlsa_pkg::rlsa_alm_t alarm_in,
	input wire logic safety_overvoltage_alarm,
	input wire logic power_fail_state_off,
	input wire logic overtemp_state_off,
	input wire rlsa_pkg::rlsa_alm_t route1,
	input wire rlsa_pkg::rlsa_alm_t route2,
	// Status
	output logic [1:0] location,
	output logic sup_expired,
	output logic dig_error,
	output logic ack_pulse,
	output logic out_enable,
	output logic ref_10v,
	output rlsa_pkg::rlsa_alm_t alarm_latched,
	output logic alarm_out1,
	output logic alarm_out2,
	// Applied set values and monitors
	output rlsa_pkg::rlsa_sv_t set_v,
	output rlsa_pkg::rlsa_sv_t set_c,
	output rlsa_pkg::rlsa_sv_t set_p,
	output rlsa_pkg::rlsa_sv_t set_r,
	output rlsa_pkg::rlsa_sv_t voltage_monitor_output,
	output rlsa_pkg::rlsa_sv_t current_monitor_output
);
	rlsa_pkg::rlsa_state_s st;
	rlsa_pkg::rlsa_state_s next_st;

	function automatic rlsa_pkg::rlsa_sv_t clip(input rlsa_pkg::rlsa_sv_t v,
		input rlsa_pkg::rlsa_sv_t lim);
		clip = (v > lim) ? lim : v;
	endfunction

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	logic any_alarm;
	logic ack_ok;
	rlsa_pkg::rlsa_alm_t need_ack;
	always_comb begin
		next_st = st;
		next_st.dig_err = 1'b0;
		next_st.ack = 1'b0;
		next_st.expired = 1'b0;
		// Millisecond time base
		next_st.ms_tick = 1'b0; // see R22
		if (st.ms_div == 17'(`RLSA_MS_CYC - 1)) begin
			next_st.ms_div = 17'h0;
			next_st.ms_tick = 1'b1;
		end else begin
			next_st.ms_div = st.ms_div + 17'h1;
		end
		// Control location
		case (st.loc)
			rlsa_pkg::RLSA_LOC_MANUAL: begin
				if (!local_lock && !remote_select_n) begin
					next_st.loc = rlsa_pkg::RLSA_LOC_ANALOG; // see R8 R10
				end else if (!local_lock && dig_req) begin
					next_st.loc = rlsa_pkg::RLSA_LOC_DIGITAL;
					next_st.to_cnt = st.to_len;
				end
			end
			rlsa_pkg::RLSA_LOC_DIGITAL: begin
				// Select pin changes ignored here, see R7
				if (local_lock || dig_release) begin
					next_st.loc = rlsa_pkg::RLSA_LOC_MANUAL; // see R9
				end else if (dig_msg) begin
					next_st.to_cnt = st.to_len; // see R2
				end else if (st.ms_tick && st.to_len != '0) begin
					if (st.to_cnt <= `RLSA_TO_W'(1)) begin
						next_st.loc = rlsa_pkg::RLSA_LOC_MANUAL; // see R3
						next_st.expired = 1'b1;
						if (!keep_on_after_remote)
							next_st.out_on = 1'b0; // see R4
					end else begin
						next_st.to_cnt = st.to_cnt - `RLSA_TO_W'(1);
					end
				end
			end
			rlsa_pkg::RLSA_LOC_ANALOG: begin
				if (dig_req)
					next_st.dig_err = 1'b1; // see R7
				// Lock pauses; returning needs select still low
				if (local_lock || remote_select_n)
					next_st.loc = rlsa_pkg::RLSA_LOC_MANUAL; // see R9
			end
			default: next_st.loc = rlsa_pkg::RLSA_LOC_MANUAL;
		endcase
		// Timeout length taken at once on any write, in every location; running count kept
		if (to_wr && st.loc != rlsa_pkg::RLSA_LOC_DIGITAL)
			next_st.to_len = to_ms;
		if (st.loc == rlsa_pkg::RLSA_LOC_DIGITAL && to_wr)
			next_st.to_len = to_ms; // see R5
		// Output enable, standby pin works in analog location only
		if (st.loc == rlsa_pkg::RLSA_LOC_ANALOG)
			next_st.out_on = output_standby_pin; // see R10
		else if (st.loc == rlsa_pkg::RLSA_LOC_MANUAL)
			next_st.out_on = manual_out_on;
		// Acknowledge by standby high-low-high
		next_st.sb_prev = output_standby_pin;
		if (output_standby_pin)
			next_st.low_ms = 6'h0;
		else if (st.ms_tick && st.low_ms != 6'h3f)
			next_st.low_ms = st.low_ms + 6'h1;
		if (ack_ok)
			next_st.ack = 1'b1; // see R19
		need_ack = rlsa_pkg::rlsa_alm_t'(6'h0f);
		need_ack[`RLSA_ALM_PWR_FAIL] = power_fail_state_off; // see R20
		need_ack[`RLSA_ALM_OVERTEMP] = overtemp_state_off;
		if (ack_ok)
			next_st.latched = alarm_in & need_ack;
		else
			next_st.latched = (st.latched & need_ack) | alarm_in;
		if (safety_overvoltage_alarm)
			next_st.safety_ov = 1'b1; // see R21
		if (any_alarm)
			next_st.out_on = 1'b0; // see R17
		// Set values, all four from one source
		// Limits come from configuration only, see R14
		if (st.loc == rlsa_pkg::RLSA_LOC_ANALOG) begin
			next_st.v_set = clip(voltage_setpoint_input, lim_v); // see R11 R13
			next_st.c_set = clip(current_setpoint_input, lim_c);
			next_st.p_set = clip(power_setpoint_input, lim_p);
			next_st.r_set = clip(resistance_setpoint_input, lim_r);
		end else begin
			next_st.v_set = clip(man_v, lim_v);
			next_st.c_set = clip(man_c, lim_c);
			next_st.p_set = clip(man_p, lim_p);
			next_st.r_set = clip(man_r, lim_r);
		end
		// Range and monitors; codes are full scale of chosen range
		next_st.range10 = range_10v_cfg | range_10v; // see R12
		next_st.v_mon = act_v;
		next_st.c_mon = act_c;
		// Alarm routing, safety shows as both
		next_st.alarm1 = |(next_st.latched & route1) |
			next_st.safety_ov; // see R18
		next_st.alarm2 = |(next_st.latched & route2) |
			next_st.safety_ov; // see R21
	end
	assign any_alarm = |alarm_in | safety_overvoltage_alarm | st.safety_ov |
		(|st.latched);
	assign ack_ok = output_standby_pin && !st.sb_prev &&
		(st.low_ms >= 6'(`RLSA_ACK_LOW_MS));

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.to_len <= `RLSA_TO_W'(`RLSA_TO_RST_MS);
		end else begin
			st <= next_st;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	// Network connection timeout is separate logic, see R6
	assign location = st.loc;
	assign sup_expired = st.expired;
	assign dig_error = st.dig_err;
	assign ack_pulse = st.ack;
	assign out_enable = st.out_on;
	assign ref_10v = st.range10;
	assign alarm_latched = st.latched;
	assign alarm_out1 = st.alarm1;
	assign alarm_out2 = st.alarm2;
	assign set_v = st.v_set; // see R15
	assign set_c = st.c_set;
	assign set_p = st.p_set;
	assign set_r = st.r_set;
	assign voltage_monitor_output = st.v_mon;
	assign current_monitor_output = st.c_mon;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	expiry_exit_a: assert property ( // see R3
		@(posedge clk) disable iff (!arst_n)
		st.expired |-> st.loc == rlsa_pkg::RLSA_LOC_MANUAL)
		else $error("expiry left remote active");

	expiry_off_a: assert property ( // see R4
		@(posedge clk) disable iff (!arst_n)
		$rose(st.expired) && !$past(keep_on_after_remote) |-> !st.out_on)
		else $error("expiry kept output on");

	msg_restart_a: assert property ( // see R2
		@(posedge clk) disable iff (!arst_n)
		st.loc == rlsa_pkg::RLSA_LOC_DIGITAL && dig_msg && !local_lock
		&& !dig_release |=> !st.expired)
		else $error("message did not restart timeout");

	analog_refuse_a: assert property ( // see R7
		@(posedge clk) disable iff (!arst_n)
		st.loc == rlsa_pkg::RLSA_LOC_ANALOG && dig_req |=> st.dig_err)
		else $error("digital request not refused");

	lock_ends_a: assert property ( // see R9
		@(posedge clk) disable iff (!arst_n)
		local_lock |=> st.loc == rlsa_pkg::RLSA_LOC_MANUAL)
		else $error("lock did not end remote");

	alarm_off_a: assert property ( // see R17
		@(posedge clk) disable iff (!arst_n)
		|alarm_in |=> !st.out_on)
		else $error("alarm left output on");

	ack_low_a: assert property ( // see R19
		@(posedge clk) disable iff (!arst_n)
		st.ack |-> $past(st.low_ms) >= 6'(`RLSA_ACK_LOW_MS))
		else $error("ack with short low phase");

	safety_stay_a: assert property ( // see R21
		@(posedge clk) disable iff (!arst_n)
		st.safety_ov |=> st.safety_ov && st.alarm1 && st.alarm2)
		else $error("safety alarm cleared");

	clip_a: assert property ( // see R13
		@(posedge clk) disable iff (!arst_n)
		1'b1 |=> st.v_set <= $past(lim_v))
		else $error("set value above limit");

	expiry_pulse_a: assert property ( // see R2
		@(posedge clk) disable iff (!arst_n)
		st.expired |=> !st.expired)
		else $error("expiry pulse too long");

	err_pulse_a: assert property ( // see R7
		@(posedge clk) disable iff (!arst_n)
		st.dig_err |-> $past(st.loc) == rlsa_pkg::RLSA_LOC_ANALOG
		&& $past(dig_req))
		else $error("error without refused request");

	ack_edge_a: assert property ( // see R19
		@(posedge clk) disable iff (!arst_n)
		st.ack |-> $past(output_standby_pin) && !$past(st.sb_prev))
		else $error("ack without rising standby edge");

	ack_clear_a: assert property ( // see R19
		@(posedge clk) disable iff (!arst_n)
		st.ack |-> (st.latched & ~$past(alarm_in)) == '0)
		else $error("ack left cleared alarm latched");

	alarm_latch_a: assert property ( // see R19
		@(posedge clk) disable iff (!arst_n)
		|alarm_in[3:0] |=>
		(st.latched[3:0] & $past(alarm_in[3:0])) == $past(alarm_in[3:0]))
		else $error("active alarm not latched");

	fail_free_a: assert property ( // see R20
		@(posedge clk) disable iff (!arst_n)
		!power_fail_state_off && !alarm_in[`RLSA_ALM_PWR_FAIL] |=>
		!st.latched[`RLSA_ALM_PWR_FAIL])
		else $error("power fail latched without need");

	temp_free_a: assert property ( // see R20
		@(posedge clk) disable iff (!arst_n)
		!overtemp_state_off && !alarm_in[`RLSA_ALM_OVERTEMP] |=>
		!st.latched[`RLSA_ALM_OVERTEMP])
		else $error("overtemperature latched without need");

	safety_seen_a: assert property ( // see R21
		@(posedge clk) disable iff (!arst_n)
		safety_overvoltage_alarm |=> st.safety_ov && st.alarm1 && st.alarm2)
		else $error("safety alarm not shown on both outputs");

	safety_off_a: assert property ( // see R17
		@(posedge clk) disable iff (!arst_n)
		st.safety_ov |-> !st.out_on)
		else $error("output on during safety alarm");

	latch_off_a: assert property ( // see R17
		@(posedge clk) disable iff (!arst_n)
		|st.latched |=> !st.out_on)
		else $error("output on with latched alarm");

	range_ref_a: assert property ( // see R12
		@(posedge clk) disable iff (!arst_n)
		1'b1 |=> st.range10 == ($past(range_10v_cfg) | $past(range_10v)))
		else $error("reference does not follow range");

	mon_follow_a: assert property ( // see R12
		@(posedge clk) disable iff (!arst_n)
		1'b1 |=> st.v_mon == $past(act_v) && st.c_mon == $past(act_c))
		else $error("monitor does not follow actual value");

	analog_take_a: assert property ( // see R11
		@(posedge clk) disable iff (!arst_n)
		st.loc == rlsa_pkg::RLSA_LOC_ANALOG && current_setpoint_input <= lim_c
		|=> st.c_set == $past(current_setpoint_input))
		else $error("analog current set value not taken");

	manual_set_a: assert property ( // see R11
		@(posedge clk) disable iff (!arst_n)
		st.loc != rlsa_pkg::RLSA_LOC_ANALOG && man_v <= lim_v
		|=> st.v_set == $past(man_v))
		else $error("manual set value mixed in");

	remote_only_a: assert property ( // see R1
		@(posedge clk) disable iff (!arst_n)
		st.loc != rlsa_pkg::RLSA_LOC_DIGITAL |=> !st.expired)
		else $error("expiry outside digital remote");

	sel_entry_a: assert property ( // see R8
		@(posedge clk) disable iff (!arst_n)
		st.loc == rlsa_pkg::RLSA_LOC_MANUAL && !local_lock && !remote_select_n
		|=> st.loc == rlsa_pkg::RLSA_LOC_ANALOG)
		else $error("select low did not enter analog");

	digital_hold_a: assert property ( // see R7
		@(posedge clk) disable iff (!arst_n)
		st.loc == rlsa_pkg::RLSA_LOC_DIGITAL && !local_lock && !dig_release
		&& !st.ms_tick |=> st.loc == rlsa_pkg::RLSA_LOC_DIGITAL)
		else $error("digital remote left without cause");

	to_keep_a: assert property ( // see R5
		@(posedge clk) disable iff (!arst_n)
		st.loc == rlsa_pkg::RLSA_LOC_DIGITAL && to_wr && !dig_msg
		&& !st.ms_tick && !local_lock && !dig_release
		|=> st.to_cnt == $past(st.to_cnt))
		else $error("timeout write altered running period");
endmodule // rlsa_top
`default_nettype wire

// ### test/rlsa_ctl.sv
// Analog controller model driving the standby pin
// Assumes go is a one-cycle pulse from the bench
`timescale 1ns/1ns
`default_nettype none
module rlsa_ctl (
	// Clock
	input wire logic clk,
	// Command
	input wire logic go,
	input wire logic [15:0] low_cyc,
	// Pin
	output logic sb
);
	logic [15:0] cnt = 16'h0000;
	// High-low-high pulse, pin idles high
	always @(posedge clk) begin
		if (go && cnt == 16'h0000) begin
			cnt <= low_cyc;
		end else if (cnt != 16'h0000) begin
			cnt <= cnt - 16'h0001;
		end
	end
	assign sb = (cnt == 16'h0000);
endmodule // rlsa_ctl
`default_nettype wire

// ### test/rlsa_top_tb.sv
// Bench of the remote link supervision block
// Assumes rlsa_ctl plays the analog controller
`timescale 1ns/1ns
`default_nettype none
module rlsa_top_tb;
	typedef struct packed {
		rlsa_pkg::rlsa_sv_t vin;
		rlsa_pkg::rlsa_sv_t lim;
		logic r10;
		rlsa_pkg::rlsa_sv_t want;
	} rlsa_row_s;
	rlsa_row_s rows [4];
	logic clk = 0, arst_n = 0, dig_req = 0, dig_release = 0, dig_msg = 0;
	logic to_wr = 0, keep_on_after_remote = 0, local_lock = 0, go = 0;
	logic manual_out_on = 1, remote_select_n = 1, range_10v = 0;
	logic range_10v_cfg = 0, power_fail_state_off = 0;
	logic overtemp_state_off = 0;
	logic safety_overvoltage_alarm = 0, output_standby_pin, sup_expired;
	logic dig_error, ack_pulse, out_enable, ref_10v, alarm_out1, alarm_out2;
	logic [1:0] location;
	logic [15:0] to_ms = 16'h0002, low_cyc = 16'h0005;
	rlsa_pkg::rlsa_sv_t voltage_setpoint_input = '0,
		current_setpoint_input = '0, power_setpoint_input = '0,
		resistance_setpoint_input = '0, man_v = 16'h0777, man_c = 16'h0777,
		man_p = 16'h0777, man_r = 16'h0777, lim_v = '1, lim_c = '1,
		lim_p = '1, lim_r = '1, act_v = '0, act_c = '0, set_v, set_c, set_p,
		set_r, voltage_monitor_output, current_monitor_output;
	rlsa_pkg::rlsa_alm_t alarm_in = '0, route1 = 6'h02, route2 = 6'h10;
	rlsa_pkg::rlsa_alm_t alarm_latched;
	int err_total = 0, check_count = 0, n;
	rlsa_ctl i_ctl (.clk, .go, .low_cyc, .sb(output_standby_pin));
	rlsa_top i_dut (.clk, .arst_n, .dig_req, .dig_release, .dig_msg,
		.to_wr, .to_ms, .keep_on_after_remote, .local_lock, .manual_out_on,
		.remote_select_n, .output_standby_pin, .range_10v, .range_10v_cfg,
		.voltage_setpoint_input, .current_setpoint_input,
		.power_setpoint_input, .resistance_setpoint_input, .man_v, .man_c,
		.man_p, .man_r, .lim_v, .lim_c, .lim_p, .lim_r, .act_v, .act_c,
		.alarm_in, .safety_overvoltage_alarm, .power_fail_state_off,
		.overtemp_state_off,
		.route1, .route2, .location, .sup_expired, .dig_error, .ack_pulse,
		.out_enable, .ref_10v, .alarm_latched, .alarm_out1, .alarm_out2,
		.set_v, .set_c, .set_p, .set_r, .voltage_monitor_output,
		.current_monitor_output);
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#5;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
	endtask
	task automatic wait_exp(input logic want_on);
		n = 0;
		while (sup_expired !== 1'b1 && n < 45000) begin
			step(1);
			n++;
		end
		chk("expired", 1, sup_expired);
		chk("out_exp", want_on, out_enable);
		step(1);
		chk("loc_exp", rlsa_pkg::RLSA_LOC_MANUAL, location);
	endtask
	task automatic final_report();
		if (err_total == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		final_report();
	end
	initial begin
		rows = '{'{16'h1000, 16'h8000, 1'b0, 16'h1000},
			'{16'hc000, 16'h8000, 1'b1, 16'h8000},
			'{16'h8000, 16'h8000, 1'b0, 16'h8000},
			'{16'hffff, 16'h0000, 1'b1, 16'h0000}};
		step(3);
		chk("loc_rst", 0, location);
		arst_n = 1;
		remote_select_n = 0;
		step(2);
		chk("loc_an", rlsa_pkg::RLSA_LOC_ANALOG, location);
		foreach (rows[i]) begin
			voltage_setpoint_input = rows[i].vin;
			current_setpoint_input = rows[i].vin;
			power_setpoint_input = rows[i].vin;
			resistance_setpoint_input = rows[i].vin;
			act_v = rows[i].vin;
			act_c = rows[i].vin;
			lim_v = rows[i].lim;
			lim_c = rows[i].lim;
			lim_p = rows[i].lim;
			lim_r = rows[i].lim;
			range_10v_cfg = rows[i].r10;
			step(2);
			chk("set_v", rows[i].want, set_v);
			chk("set_c", rows[i].want, set_c);
			chk("set_p", rows[i].want, set_p);
			chk("ref", rows[i].r10, ref_10v);
			chk("voltage_monitor_output", rows[i].vin, voltage_monitor_output);
			chk("set_r", rows[i].want, set_r);
			chk("current_monitor_output", rows[i].vin, current_monitor_output);
		end
		pulse(dig_req);
		chk("dig_err", 1, dig_error);
		local_lock = 1;
		step(2);
		chk("loc_lk", rlsa_pkg::RLSA_LOC_MANUAL, location);
		local_lock = 0;
		step(2);
		chk("loc_unlk", rlsa_pkg::RLSA_LOC_ANALOG, location);
		remote_select_n = 1;
		step(2);
		pulse(to_wr);
		keep_on_after_remote = 1;
		pulse(dig_req);
		remote_select_n = 0;
		step(2);
		chk("loc_dg", rlsa_pkg::RLSA_LOC_DIGITAL, location);
		remote_select_n = 1;
		repeat (3) begin
			pulse(dig_msg);
			step(14000);
		end
		chk("loc_msg", rlsa_pkg::RLSA_LOC_DIGITAL, location);
		to_ms = 16'h0001;
		pulse(to_wr);
		chk("loc_wr", rlsa_pkg::RLSA_LOC_DIGITAL, location);
		pulse(dig_msg);
		wait_exp(1'b1);
		chk("out_man", 1, out_enable);
		keep_on_after_remote = 0;
		pulse(dig_req);
		wait_exp(1'b0);
		chk("out_man2", 1, out_enable);
		pulse(dig_req);
		local_lock = 1;
		step(2);
		local_lock = 0;
		step(2);
		chk("loc_dlk", rlsa_pkg::RLSA_LOC_MANUAL, location);
		alarm_in = 6'h02;
		step(2);
		alarm_in = '0;
		pulse(go);
		step(10);
		chk("latch", 6'h02, alarm_latched);
		chk("ack_short", 0, ack_pulse);
		chk("out_alm", 0, out_enable);
		chk("a_out1", 1, alarm_out1);
		chk("a_out2", 0, alarm_out2);
		alarm_in = 6'h10;
		step(2);
		alarm_in = '0;
		step(2);
		chk("pwr_fail_on", 6'h02, alarm_latched);
		power_fail_state_off = 1;
		alarm_in = 6'h10;
		step(2);
		alarm_in = '0;
		step(2);
		chk("pwr_fail_off", 6'h12, alarm_latched);
		arst_n = 0;
		step(1);
		chk("loc_rst2", 0, location);
		chk("out_rst2", 0, out_enable);
		arst_n = 1;
		safety_overvoltage_alarm = 1;
		step(2);
		safety_overvoltage_alarm = 0;
		pulse(go);
		step(10);
		chk("safety_latch", 6'h00, alarm_latched);
		chk("safety_out1", 1, alarm_out1);
		chk("safety_out2", 1, alarm_out2);
		chk("safety_off", 0, out_enable);
		final_report();
	end
endmodule // rlsa_top_tb
`default_nettype wire
